/* design/flash_prot_map.svh */
`ifndef FLASH_PROT_MAP_SVH
`define FLASH_PROT_MAP_SVH
// Register indices on the CPU register port
`define R_CTRL0H  4'h0
`define R_ERLO    4'h1
`define R_ERHI    4'h2
`define R_ADDRL   4'h3
`define R_ADDRH   4'h4
`define R_D0L     4'h5
`define R_D0H     4'h6
`define R_D1L     4'h7
`define R_D1H     4'h8
`define R_ERR     4'h9
`define R_TAU     4'ha
`define R_WPFUSE  4'hb
`define R_AF0     4'hc
`define R_AF1L    4'hd
`define R_AF1H    4'he
// Control register 0 high bit positions
`define C_START   15
`define C_SUSPEND_SEL    14
`define C_WPG     13
`define C_DOUBLE_WORD_PROG_SEL    12
`define C_SER     11
`define C_SPR     8
// Error register bit positions
`define E_RESUME_ERROR_FLAG   4
`define E_WPF     5
// Protection constants
`define TRAP_VEC  16'h009b
`define FUSE_ADDRH 16'h0008
`define AF1_ADDRL 16'hdfbc
`define AF0_ADDRL 16'hdfb8
`define WPF_ADDRL 16'hdfb4
`define ACCESS_PROTECT_FUSE_BIT  0
`define SECT_N    10
`define PAIRS     16
`define FUSE_RST  16'hffff
`define SEC_MSB   16
`define SEC_LSB   13
`endif

/* design/flash_prot_pkg.sv */
`include "flash_prot_map.svh"
package flash_prot_pkg;
  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_PROG  = 5'h02,
    S_ERASE = 5'h04,
    S_SUSPEND_SEL  = 5'h08,
    S_PSUSP = 5'h10
  } op_state_t;
  typedef enum logic [2:0] {
    K_NONE = 3'h0, K_WORD = 3'h1, K_DWORD = 3'h2, K_ERASE = 3'h3, K_SETP = 3'h4
  } op_kind_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        is_reg;
    logic        is_array;
    logic [3:0]  idx;
    logic [15:0] wdata;
    logic        indirect;
    logic        from_flash;
    logic        event_transfer_ctrl;
  } cpu_req_t;
  typedef struct packed {
    logic              start;
    op_kind_t          kind;
    logic [31:0]       addr;
    logic [63:0]       data;
    logic [`SECT_N-1:0] sectors;
  } arr_cmd_t;
endpackage

/* design/flash_protect_write_ctrl.sv */
`timescale 1ns/1ps
`include "flash_prot_map.svh"
// Summary of operation
// RULE1: Temporary unlock bit at 1 suspends access protection entirely.
// RULE2: Unlock bit is writable only by instructions fetched from internal flash.
// RULE3: Fuse 0 and unlock 0: flash data readable only while fetching from flash.
// RULE4: Protected: flash writes from RAM or external code are discarded.
// RULE5: Protected: reads from RAM or external code return dummy data, trap 0x009B.
// RULE6: Protected: event transfer controller flash accesses are blocked too.
// RULE7: Protected: control register writes blocked, reads still allowed.
// RULE8: Up to 16 permanent disable/re-enable steps, each needing temporary unlock.
// RULE9: Sectors whose protect fuse bit is 0 cannot be programmed or erased.
// RULE10: Set protection writing 1 only sets the volatile copy; fuse reads stay 0.
// RULE11: Sector protection returns on reset or set protection writing 0.
// RULE12: Access protection returns on reset or unlock bit written back to 0.
// RULE13: Software issues write commands from RAM or external memory only.
// RULE14: Control writes must be indirect and 16 bits; direct writes are rejected.
// RULE15: Double word program ignores address bit 2, aligning to an even word.
// RULE16: Suspend bit suspends word, double word program or sector erase.
// RULE17: Resume with mismatched select bits aborts and sets resume error flag.
// RULE18: Both erase select registers clear to zero when an erase finishes.
// RULE19: Program during erase suspend cannot be suspended; erase select resumes.
// RULE20: Software never starts a write operation with suspend still set.
// RULE21: Start 0x8000, double word 0x1000, erase 0x0800; erase plus start resumes.
// RULE22: Protected sectors skipped, others still erased, write protect flag set.
// RULE23: Disable fuse 0 with its enable fuse still 1 cancels the access fuse.
// RULE24: Select, load address/data, then start; clearing select cancels.
// RULE25: A one-cycle violation event accompanies each dummy read.
module flash_protect_write_ctrl
  import flash_prot_pkg::*;
(
  input  wire logic               core_clk_in,
  input  wire logic               resetn_in,
  input  wire cpu_req_t           req_in,
  input  wire logic [15:0]        arr_rdata_in,
  input  wire logic               arr_done_in,
  input  wire logic [`SECT_N-1:0] nv_wp_in,
  input  wire logic [15:0]        nv_af0_in,
  input  wire logic [15:0]        nv_af1l_in,
  input  wire logic [15:0]        nv_af1h_in,
  output logic                    rsp_valid_out,
  output logic [15:0]             rsp_data_out,
  output logic                    trap_out,
  output logic [15:0]             trap_vec_out,
  output logic                    arr_wr_out,
  output logic                    arr_hold_out,
  output arr_cmd_t                arr_cmd_out
);
  op_state_t          state;
  logic               loaded, temp_access_unlock_bit, access_protect_fuse, suspend_sel, set_protection_sel;
  logic [2:0]         sel, saved;
  logic [15:0]        er_lo, er_hi, a_lo, a_hi, d0l, d0h, d1l, d1h, err;
  logic [`SECT_N-1:0] wp_vol, wp_nv;
  logic [15:0]        pds, pen, af0_raw;
  wire  [15:0]        pds_nx, pen_nx;

  // Request decode
  wire        rd_acc  = req_in.valid & ~req_in.write;
  wire        wr_acc  = req_in.valid & req_in.write;
  wire [3:0]  idx     = req_in.idx;
  wire [15:0] wd      = req_in.wdata;
  wire        cancel  = |(~pds & pen);                       // [RULE23]
  wire        prot    = ~access_protect_fuse & ~cancel & ~temp_access_unlock_bit;             // [RULE1] [RULE12]
  wire        data_ok = ~prot | (req_in.from_flash & ~req_in.event_transfer_ctrl); // [RULE3] [RULE6]
  wire        reg_wr  = wr_acc & req_in.is_reg & req_in.indirect & loaded; // [RULE14]
  wire        tau_wr  = reg_wr & (idx == `R_TAU) & req_in.from_flash & ~req_in.event_transfer_ctrl; // [RULE2]
  wire        ctl_wr  = reg_wr & (idx != `R_TAU) & ~prot;    // [RULE7]
  wire        c0_wr   = ctl_wr & (idx == `R_CTRL0H);
  wire        start   = c0_wr & wd[`C_START];                // [RULE21]
  wire        suspend_sel_rq = c0_wr & wd[`C_SUSPEND_SEL] & ~wd[`C_START]; // [RULE16]
  wire [2:0]  eff     = sel | {wd[`C_WPG], wd[`C_DOUBLE_WORD_PROG_SEL], wd[`C_SER]};

  // Address, sector and protection checks
  wire [31:0] faddr   = {a_hi, a_lo};
  wire [31:0] paddr   = eff[1] ? {faddr[31:3], 1'b0, faddr[1:0]} : faddr; // [RULE15]
  wire [3:0]  sec     = faddr[`SEC_MSB:`SEC_LSB];
  wire [15:0] wp_ext  = {{(16-`SECT_N){1'b1}}, wp_vol};
  wire        pg_prot = ~wp_ext[sec];                        // [RULE9]
  wire [`SECT_N-1:0] er_go  = er_lo[`SECT_N-1:0] & wp_vol;   // [RULE22]
  wire               er_hit = |(er_lo[`SECT_N-1:0] & ~wp_vol);

  // Operation launch terms; a pending suspend bit blocks any start from idle
  wire        idle_st = (state == S_IDLE) & start & ~suspend_sel;
  wire        prog_go = idle_st & (eff[2] | eff[1]);
  wire        erase_go = idle_st & ~eff[2] & ~eff[1] & eff[0];
  wire        setp_go = idle_st & (eff == 3'b000) & (set_protection_sel | wd[`C_SPR]);
  wire        in_suspend_sel = (state == S_SUSPEND_SEL) & start;
  wire        resume  = in_suspend_sel & (eff == saved);            // [RULE21]
  wire        ps_go   = in_suspend_sel & ~resume & (saved == 3'b001) & (eff[2] ^ eff[1]); // [RULE19]
  wire        abort   = in_suspend_sel & ~resume & ~ps_go;          // [RULE17]
  wire        launch_p = (prog_go | ps_go) & ~pg_prot;
  wire        launch_e = erase_go & (|er_go);
  wire        set_wpf  = ((prog_go | ps_go) & pg_prot) | (erase_go & er_hit); // [RULE22]
  wire        er_done  = arr_done_in & ((state == S_ERASE) | ((state == S_SUSPEND_SEL) & saved[0]));
  wire        op_end   = arr_done_in & ((state == S_PROG) | (state == S_ERASE));
  wire        tgt_fuse = (a_hi == `FUSE_ADDRH);
  wire        tgt_wp   = tgt_fuse & (a_lo == `WPF_ADDRL);
  wire        tgt_af0  = tgt_fuse & (a_lo == `AF0_ADDRL);
  wire        tgt_af1  = tgt_fuse & (a_lo == `AF1_ADDRL) & temp_access_unlock_bit; // [RULE8]

  // Disable/re-enable pairs: each fuse may only go to 0 after its predecessor
  genvar g;
  generate
    for (g = 0; g < `PAIRS; g++) begin : g_pair
      if (g == 0) begin : g_first
        assign pds_nx[g] = pds[g] & (d0l[g] | access_protect_fuse);         // [RULE8]
      end else begin : g_rest
        assign pds_nx[g] = pds[g] & (d0l[g] | pen[g-1]);     // [RULE8]
      end
      assign pen_nx[g] = pen[g] & (d0h[g] | pds[g]);         // [RULE8]
    end
  endgenerate

  // Register read selection; reads stay open under protection
  wire [15:0] c0_rd = {state != S_IDLE, suspend_sel, sel, 2'b00, set_protection_sel, 8'h00};
  wire [15:0] rd_reg =
    (idx == `R_CTRL0H) ? c0_rd :
    (idx == `R_ERLO)   ? er_lo :
    (idx == `R_ERHI)   ? er_hi :
    (idx == `R_ADDRL)  ? a_lo :
    (idx == `R_ADDRH)  ? a_hi :
    (idx == `R_D0L)    ? d0l :
    (idx == `R_D0H)    ? d0h :
    (idx == `R_D1L)    ? d1l :
    (idx == `R_D1H)    ? d1h :
    (idx == `R_ERR)    ? err :
    (idx == `R_TAU)    ? {15'h0000, temp_access_unlock_bit} :
    (idx == `R_WPFUSE) ? {{(16-`SECT_N){1'b1}}, wp_nv} :    // [RULE10]
    (idx == `R_AF0)    ? af0_raw :
    (idx == `R_AF1L)   ? pds :
    (idx == `R_AF1H)   ? pen : 16'h0000;

  // Read response, trap event and data write gate
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      rsp_valid_out <= 1'b0;
      rsp_data_out  <= 16'h0000;
      trap_out      <= 1'b0;
      trap_vec_out  <= `TRAP_VEC;
      arr_wr_out    <= 1'b0;
    end else begin
      rsp_valid_out <= rd_acc;
      rsp_data_out  <= req_in.is_array ? (data_ok ? arr_rdata_in : 16'h0000) : rd_reg; // [RULE5]
      trap_out      <= rd_acc & req_in.is_array & ~data_ok;  // [RULE5] [RULE25]
      trap_vec_out  <= `TRAP_VEC;
      arr_wr_out    <= wr_acc & req_in.is_array & data_ok;   // [RULE4] [RULE6]
    end
  end

  // Temporary unlock bit; reset restores access protection
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) temp_access_unlock_bit <= 1'b0;                            // [RULE12]
    else if (tau_wr) temp_access_unlock_bit <= wd[0];                          // [RULE2] [RULE12]
  end

  // Protections forced on during reset, fuse copies caught one cycle after release
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      loaded  <= 1'b0;
      wp_vol  <= '0;
      wp_nv   <= '0;
      access_protect_fuse    <= 1'b0;
      af0_raw <= 16'h0000;
      pds     <= `FUSE_RST;
      pen     <= `FUSE_RST;
    end else if (!loaded) begin
      loaded  <= 1'b1;
      wp_vol  <= nv_wp_in;                                   // [RULE11]
      wp_nv   <= nv_wp_in;
      access_protect_fuse    <= nv_af0_in[`ACCESS_PROTECT_FUSE_BIT];
      af0_raw <= nv_af0_in;
      pds     <= nv_af1l_in;
      pen     <= nv_af1h_in;
    end else if (setp_go) begin
      if (tgt_wp) begin
        wp_vol <= d0l[`SECT_N-1:0];                          // [RULE10] [RULE11]
        wp_nv  <= wp_nv & d0l[`SECT_N-1:0];                  // [RULE10]
      end
      if (tgt_af0) begin
        access_protect_fuse    <= access_protect_fuse & d0l[`ACCESS_PROTECT_FUSE_BIT];
        af0_raw <= af0_raw & d0l;
      end
      if (tgt_af1) begin
        pds <= pds_nx;                                       // [RULE8]
        pen <= pen_nx;
      end
    end
  end

  // Address, data and erase select registers
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      {a_lo, a_hi, d0l, d0h, d1l, d1h} <= '0;
      er_lo <= 16'h0000;
      er_hi <= 16'h0000;
    end else begin
      if (ctl_wr & (idx == `R_ADDRL)) a_lo <= wd;
      if (ctl_wr & (idx == `R_ADDRH)) a_hi <= wd;
      if (ctl_wr & (idx == `R_D0L)) d0l <= wd;
      if (ctl_wr & (idx == `R_D0H)) d0h <= wd;
      if (ctl_wr & (idx == `R_D1L)) d1l <= wd;
      if (ctl_wr & (idx == `R_D1H)) d1h <= wd;
      if (er_done) begin
        er_lo <= 16'h0000;                                   // [RULE18]
        er_hi <= 16'h0000;                                   // [RULE18]
      end else begin
        if (ctl_wr & (idx == `R_ERLO)) er_lo <= wd;
        if (ctl_wr & (idx == `R_ERHI)) er_hi <= wd;
      end
    end
  end

  // Control register 0 and error flags; hardware set wins over software clear
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      {sel, suspend_sel, set_protection_sel} <= '0;
      err <= 16'h0000;
    end else begin
      err <= ((ctl_wr & (idx == `R_ERR)) ? wd : err)
             | ({15'h0000, abort} << `E_RESUME_ERROR_FLAG)               // [RULE17]
             | ({15'h0000, set_wpf} << `E_WPF);              // [RULE22]
      if (op_end | abort | er_done | setp_go | set_wpf | (state == S_PSUSP & arr_done_in)) begin
        sel <= 3'b000;
        set_protection_sel <= 1'b0;
      end else if (c0_wr & wd[`C_START]) begin
        sel <= eff;
      end else if (c0_wr) begin
        sel  <= {wd[`C_WPG], wd[`C_DOUBLE_WORD_PROG_SEL], wd[`C_SER]};       // [RULE24]
        suspend_sel <= wd[`C_SUSPEND_SEL];
        set_protection_sel  <= wd[`C_SPR];
      end
    end
  end

  // Operation sequencer
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state        <= S_IDLE;
      saved        <= 3'b000;
      arr_hold_out <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (launch_p) state <= S_PROG;
          else if (launch_e) state <= S_ERASE;
        end
        S_PROG, S_ERASE: begin
          if (arr_done_in) begin
            state <= S_IDLE;
          end else if (suspend_sel_rq) begin
            state        <= S_SUSPEND_SEL;                          // [RULE16]
            saved        <= (state == S_ERASE) ? 3'b001 : sel;
            arr_hold_out <= 1'b1;
          end
        end
        S_SUSPEND_SEL: begin
          if (er_done | abort) begin
            state        <= S_IDLE;                          // [RULE17]
            arr_hold_out <= 1'b0;
          end else if (resume) begin
            state        <= saved[0] ? S_ERASE : S_PROG;     // [RULE21]
            arr_hold_out <= 1'b0;
          end else if (launch_p) begin
            state <= S_PSUSP;                                // [RULE19]
          end
        end
        S_PSUSP: if (arr_done_in) state <= S_SUSPEND_SEL;           // [RULE19]
      endcase
    end
  end

  // Array command pulse
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      arr_cmd_out <= '0;
    end else begin
      arr_cmd_out.start   <= launch_p | launch_e | setp_go;
      arr_cmd_out.kind    <= setp_go ? K_SETP : launch_e ? K_ERASE :
                             eff[1] ? K_DWORD : launch_p ? K_WORD : K_NONE;
      arr_cmd_out.addr    <= paddr;                          // [RULE15]
      arr_cmd_out.data    <= {d1h, d1l, d0h, d0l};
      arr_cmd_out.sectors <= er_go;                          // [RULE9] [RULE22]
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  a_tau_guard: assert property (loaded && reg_wr && idx == `R_TAU && !req_in.from_flash // [RULE2]
    |=> $stable(temp_access_unlock_bit)) else $error("unlock bit changed by non-flash code");
  a_reg_block: assert property (prot && reg_wr && idx == `R_ADDRL // [RULE7]
    |=> $stable(a_lo)) else $error("register written while protected");
  a_trap_dummy: assert property (rd_acc && req_in.is_array && prot && !req_in.from_flash // [RULE5]
    |=> trap_out && rsp_data_out == 16'h0000 && trap_vec_out == `TRAP_VEC)
    else $error("protected read not trapped");
  a_unlock_open: assert property (temp_access_unlock_bit && rd_acc && req_in.is_array // [RULE1]
    |=> !trap_out && rsp_data_out == $past(arr_rdata_in)) else $error("unlocked read blocked");
  a_pec_block: assert property (prot && wr_acc && req_in.is_array && req_in.event_transfer_ctrl // [RULE6]
    |=> !arr_wr_out) else $error("event transfer write passed protection");
  a_dword_align: assert property (arr_cmd_out.start && arr_cmd_out.kind == K_DWORD // [RULE15]
    |-> !arr_cmd_out.addr[2]) else $error("double word not aligned");
  a_erase_clear: assert property (state == S_ERASE && arr_done_in // [RULE18]
    |=> er_lo == 16'h0000 && er_hi == 16'h0000 && state == S_IDLE)
    else $error("erase select not cleared");
  a_resume_err: assert property (abort |=> err[`E_RESUME_ERROR_FLAG] && state == S_IDLE) // [RULE17]
    else $error("bad resume not aborted");
  a_wp_skip: assert property (arr_cmd_out.start && arr_cmd_out.kind == K_ERASE // [RULE22]
    |-> (arr_cmd_out.sectors & ~wp_vol) == '0) else $error("protected sector erased");
  a_psusp_hold: assert property (state == S_PSUSP && suspend_sel_rq && !arr_done_in // [RULE19]
    |=> state == S_PSUSP) else $error("program in erase suspend was suspended");
endmodule

/* verification/flash_array_model.sv */
`timescale 1ns/1ps
// Behavioural flash array: fixed read word, operations end after LAT running cycles
module flash_array_model
  import flash_prot_pkg::*;
#(
  parameter int          LAT     = 40,
  parameter logic [15:0] RD_WORD = 16'hc3a5
)(
  input  wire logic     core_clk_in,
  input  wire arr_cmd_t cmd_in,
  input  wire logic     hold_in,
  output logic [15:0]   rdata_out,
  output logic          done_out
);
  logic [7:0] cnt  = 8'h00;
  logic [7:0] save = 8'h00;
  logic       nest = 1'b0;

  assign rdata_out = RD_WORD;

  // Frozen while held; a program launched inside an erase suspend runs anyway
  always @(posedge core_clk_in) begin
    done_out <= 1'b0;
    if (cmd_in.start && cmd_in.kind != K_SETP) begin
      cnt  <= 8'(LAT);
      nest <= hold_in;
      save <= cnt; // Remaining erase time survives the nested program
    end else if (cnt != 8'h00 && (!hold_in || nest)) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h01) begin
        done_out <= 1'b1;
        nest     <= 1'b0;
        cnt      <= nest ? save : 8'h00;
      end
    end
  end
endmodule

/* verification/test_flash_protect_write_ctrl.sv */
`timescale 1ns/1ps
`include "flash_prot_map.svh"
module test_flash_protect_write_ctrl
  import flash_prot_pkg::*;
;
  typedef struct packed {
    logic [1:0]  ph;
    logic        wr, rg, ar;
    logic [3:0]  idx;
    logic [15:0] wd;
    logic        ind, ff, event_transfer_ctrl, ev;
    logic [15:0] ed;
    logic        et, ew;
  } row_t;
  localparam logic [15:0] RD = 16'hc3a5;
  logic                clk;
  logic                resetn;
  cpu_req_t            req;
  logic [15:0]         arr_rdata;
  logic                arr_done;
  logic [`SECT_N-1:0]  nv_wp;
  logic [15:0]         nv_af0, nv_af1l, nv_af1h;
  logic                rsp_valid, trap, arr_wr, arr_hold;
  logic [15:0]         rsp_data, trap_vec, dm;
  arr_cmd_t            arr_cmd, cmd;
  logic [1:0]          cur;
  int                  miscompares = 0;
  int                  n_compared = 0;
  int                  cyc = 0;
  // Columns: phase, write, reg, array, idx, wdata, indirect, from flash, pec, exp rsp
  row_t rows [23] = '{
    '{2'h0,1,1,0,4'h3,16'h5558,1,0,0,0,16'h0000,0,0},
    '{2'h0,0,1,0,4'h3,16'h0000,1,0,0,1,16'h5558,0,0},
    '{2'h0,1,1,0,4'h3,16'h1234,0,0,0,0,16'h0000,0,0},
    '{2'h0,0,1,0,4'h3,16'h0000,1,0,0,1,16'h5558,0,0},
    '{2'h0,0,0,1,4'h0,16'h0000,1,0,0,1,RD,0,0},
    '{2'h0,1,1,0,4'ha,16'h0001,1,0,0,0,16'h0000,0,0},
    '{2'h0,0,1,0,4'ha,16'h0000,1,0,0,1,16'h0000,0,0},
    '{2'h1,0,0,1,4'h0,16'h0000,1,0,0,1,16'h0000,1,0},
    '{2'h1,0,0,1,4'h0,16'h0000,1,1,0,1,RD,0,0},
    '{2'h1,0,0,1,4'h0,16'h0000,1,1,1,1,16'h0000,1,0},
    '{2'h1,1,0,1,4'h0,16'h1111,1,0,0,0,16'h0000,0,0},
    '{2'h1,1,0,1,4'h0,16'h1111,1,1,0,0,16'h0000,0,1},
    '{2'h1,1,1,0,4'h3,16'h5558,1,0,0,0,16'h0000,0,0},
    '{2'h1,0,1,0,4'h3,16'h0000,1,0,0,1,16'h0000,0,0},
    '{2'h1,1,1,0,4'ha,16'h0001,1,1,0,0,16'h0000,0,0},
    '{2'h1,0,1,0,4'ha,16'h0000,1,0,0,1,16'h0001,0,0},
    '{2'h1,0,0,1,4'h0,16'h0000,1,0,0,1,RD,0,0},
    '{2'h1,0,0,1,4'h0,16'h0000,1,0,1,1,RD,0,0},
    '{2'h1,1,1,0,4'h3,16'h5558,1,0,0,0,16'h0000,0,0},
    '{2'h1,0,1,0,4'h3,16'h0000,1,0,0,1,16'h5558,0,0},
    '{2'h1,1,1,0,4'ha,16'h0000,1,1,0,0,16'h0000,0,0},
    '{2'h1,0,0,1,4'h0,16'h0000,1,0,0,1,16'h0000,1,0},
    '{2'h2,0,0,1,4'h0,16'h0000,1,0,0,1,RD,0,0}
  };

  flash_protect_write_ctrl flash_protect_write_ctrl_inst (
    .core_clk_in(clk), .resetn_in(resetn), .req_in(req), .arr_rdata_in(arr_rdata),
    .arr_done_in(arr_done), .nv_wp_in(nv_wp), .nv_af0_in(nv_af0), .nv_af1l_in(nv_af1l),
    .nv_af1h_in(nv_af1h), .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data),
    .trap_out(trap), .trap_vec_out(trap_vec), .arr_wr_out(arr_wr),
    .arr_hold_out(arr_hold), .arr_cmd_out(arr_cmd)
  );
  flash_array_model #(.LAT(40), .RD_WORD(RD)) flash_array_model_inst (
    .core_clk_in(clk), .cmd_in(arr_cmd), .hold_in(arr_hold),
    .rdata_out(arr_rdata), .done_out(arr_done)
  );

  // Clock and hang guard; a few hundred cycles are needed, the ceiling is generous
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    n_compared++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  // One access, held over one edge; outputs looked at once that edge has landed
  task automatic acc(input row_t r);
    @(posedge clk);
    #1 req = '{1'b1, r.wr, r.rg, r.ar, r.idx, r.wd, r.ind, r.ff, r.event_transfer_ctrl};
    @(posedge clk);
    #1 req = '0;
    cmd = arr_cmd;
    chk("rsp_valid", 64'(r.ev), 64'(rsp_valid));
    if (r.ev) chk("rsp_data", 64'(r.ed & dm), 64'(rsp_data & dm));
    chk("trap", 64'(r.et), 64'(trap));
    chk("arr_wr", 64'(r.ew), 64'(arr_wr));
  endtask
  task automatic wr(input logic [3:0] i, input logic [15:0] d);
    acc('{2'h0,1,1,0,i,d,1,0,0,0,16'h0000,0,0});
  endtask
  task automatic rd(input logic [3:0] i, input logic [15:0] e);
    acc('{2'h0,0,1,0,i,16'h0000,1,0,0,1,e,0,0});
  endtask
  task automatic cmd_is(input op_kind_t k);
    chk("cmd_start", 64'(k != K_NONE), 64'(cmd.start));
    if (k != K_NONE) chk("cmd_kind", 64'(k), 64'(cmd.kind));
  endtask
  task automatic hold_is(input logic v);
    @(posedge clk);
    #1 chk("arr_hold", 64'(v), 64'(arr_hold));
  endtask
  task automatic wait_done();
    for (int n = 0; n < 300 && arr_done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("arr_done", 64'h1, 64'(arr_done));
  endtask
  task automatic word_prog(input logic [15:0] al);
    wr(4'h0, 16'h2000);
    wr(4'h4, 16'h0000);
    wr(4'h3, al);
    wr(4'h0, 16'h8000);
  endtask
  task automatic set_prot(input logic [15:0] al, input logic [15:0] d);
    wr(4'h0, 16'h0100);
    wr(4'h4, 16'h0008);
    wr(4'h3, al);
    wr(4'h5, d);
    wr(4'h0, 16'h8000);
    cmd_is(K_SETP);
  endtask
  // Fuse image per phase: open, access fuse set, access fuse cancelled
  task automatic do_reset(input logic [1:0] ph);
    @(posedge clk);
    #1 resetn = 1'b0;
    nv_af0 = (ph == 2'h0) ? 16'hffff : 16'hfffe;
    nv_af1l = (ph == 2'h2) ? 16'hfffe : 16'hffff;
    repeat (20) @(posedge clk);
    #1 chk("rst_out", 64'h0, 64'({rsp_valid, trap, arr_wr, arr_hold, arr_cmd.start}));
    chk("trap_vec", 64'(`TRAP_VEC), 64'(trap_vec));
    resetn = 1'b1;
  endtask

  initial begin
    req = '0;
    resetn = 1'b0;
    nv_wp = 10'h3fb;
    nv_af0 = 16'hffff;
    nv_af1l = 16'hffff;
    nv_af1h = 16'hffff;
    dm = 16'hffff;
    cur = 2'h3;
    for (int i = 0; i < 23; i++) begin
      if (rows[i].ph != cur) begin
        cur = rows[i].ph;
        do_reset(cur);
      end
      acc(rows[i]);
    end
    do_reset(2'h0);
    // Double word at an odd word address
    wr(4'h0, 16'h1000);
    wr(4'h3, 16'h555c);
    wr(4'h4, 16'h0003);
    wr(4'h5, 16'h55aa);
    wr(4'h6, 16'h55aa);
    wr(4'h7, 16'haa55);
    wr(4'h8, 16'haa55);
    wr(4'h0, 16'h8000);
    cmd_is(K_DWORD);
    chk("cmd_addr", 64'h0000_0000_0003_5558, 64'(cmd.addr));
    chk("cmd_data", 64'haa55_aa55_55aa_55aa, cmd.data);
    wait_done();
    rd(4'h0, 16'h0000);
    // Suspend a word program, resume with the wrong select
    word_prog(16'h0000);
    cmd_is(K_WORD);
    wr(4'h0, 16'h4000);
    hold_is(1'b1);
    wr(4'h0, 16'h1000);
    wr(4'h0, 16'h8000);
    wait_done();
    rd(`R_ERR, 16'h0010);
    hold_is(1'b0);
    wr(`R_ERR, 16'h0000);
    // Program into the protected sector
    word_prog(16'h4000);
    cmd_is(K_NONE);
    rd(`R_ERR, 16'h0020);
    wr(`R_ERR, 16'h0000);
    // Erase over a protected sector, suspend, program, resume
    wr(4'h0, 16'h0800);
    wr(`R_ERLO, 16'h0007);
    wr(4'h0, 16'h8000);
    cmd_is(K_ERASE);
    chk("cmd_sect", 64'h3, 64'(cmd.sectors));
    rd(`R_ERR, 16'h0020);
    wr(4'h0, 16'h4000);
    hold_is(1'b1);
    wr(4'h0, 16'h0000);
    word_prog(16'h0000);
    cmd_is(K_WORD);
    wr(4'h0, 16'h4000);
    wait_done();
    wr(4'h0, 16'h0800);
    wr(4'h0, 16'h8000);
    hold_is(1'b0);
    wait_done();
    rd(`R_ERLO, 16'h0000);
    rd(`R_ERHI, 16'h0000);
    wr(`R_ERR, 16'h0000);
    // Temporary unprotection of sector 2, then protection restored
    set_prot(16'hdfb4, 16'h03ff);
    dm = 16'h03ff;
    rd(`R_WPFUSE, 16'h03fb);
    dm = 16'hffff;
    word_prog(16'h4000);
    cmd_is(K_WORD);
    wait_done();
    set_prot(16'hdfb4, 16'h03fb);
    word_prog(16'h4000);
    cmd_is(K_NONE);
    // Permanent disable step under temporary unlock; an out of order step is ignored
    do_reset(2'h1);
    acc('{2'h1,1,1,0,4'ha,16'h0001,1,1,0,0,16'h0000,0,0});
    set_prot(16'hdfbc, 16'hfffe);
    wr(4'h6, 16'hffff);
    set_prot(16'hdfbc, 16'hfffc);
    rd(`R_AF1L, 16'hfffe);
    rd(`R_AF1H, 16'hffff);
    acc('{2'h1,1,1,0,4'ha,16'h0000,1,1,0,0,16'h0000,0,0});
    acc('{2'h1,0,0,1,4'h0,16'h0000,1,0,0,1,RD,0,0});
    close_out();
  end
endmodule
